// ==== rtl/ckm_top.sv ====
// How it works
// - Pick high selects clock one, low clock two
// - Pick change parks low within three old cycles
// - Park at most three new cycles, then follow
// - Changeover works for any input rate supported
// - Force pick switches even without a clock
// - Gate high drives outputs to disable level unless power down is active
// - Disable level sets the true output, complement gets its inverse
// - Power down pulls both outputs high
// - Selected clock copied to all six pairs
`timescale 1ns/100ps
`include "ckm_map.svh"

module ckm_top
  import ckm_pkg::*;
#(
  parameter int NUM_OUT = `CKM_NUM_OUTPUTS
) (
  input  wire logic               SYS_CLK_IN,
  input  wire logic               SRST_IN,
  input  wire logic               CLK1_IN,
  input  wire logic               CLK2_IN,
  input  wire logic               INPUT_PICK_IN,
  input  wire logic               FORCE_PICK_IN,
  input  wire logic               OUT_GATE_N_IN,
  input  wire logic               DISABLE_LEVEL_IN,
  input  wire logic               POWER_DOWN_N_IN,
  output logic      [NUM_OUT-1:0] CLK_OUT,
  output logic      [NUM_OUT-1:0] CLK_OUT_N_OUT,
  output logic                    ACTIVE_PICK_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [`CKM_NUM_SYNC-1:0] raw;
  logic [`CKM_NUM_SYNC-1:0] syn;

  assign raw = {POWER_DOWN_N_IN, DISABLE_LEVEL_IN, OUT_GATE_N_IN, FORCE_PICK_IN,
                INPUT_PICK_IN, CLK2_IN, CLK1_IN};

  ckm_sync #(
    .WIDTH (`CKM_NUM_SYNC)
  ) u_sync (
    .clk_in   (SYS_CLK_IN),
    .srst_in  (SRST_IN),
    .async_in (raw),
    .sync_out (syn)
  );

  logic clk1_s;
  logic clk2_s;
  logic pick_s;
  logic force_s;
  logic gate_n_s;
  logic level_s;
  logic pwr_n_s;

  assign clk1_s   = syn[`CKM_BIT_CLK1];
  assign clk2_s   = syn[`CKM_BIT_CLK2];
  assign pick_s   = syn[`CKM_BIT_PICK];
  assign force_s  = syn[`CKM_BIT_FORCE];
  assign gate_n_s = syn[`CKM_BIT_GATE_N];
  assign level_s  = syn[`CKM_BIT_LEVEL];
  assign pwr_n_s  = syn[`CKM_BIT_PWR_N];

  function automatic logic pick_clk(input logic sel, input logic c1, input logic c2);
    pick_clk = sel ? c1 : c2;
  endfunction : pick_clk

  ////////////////////////////////////////////////////////////////////////////
  // Changeover sequence

  ckm_state_t state_q;
  ckm_state_t state_d;
  logic       cur_q;
  logic       cur_d;
  logic       next_q;
  logic       next_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       old_prev_q;
  logic       old_prev_d;
  logic       old_clk;
  logic       new_clk;
  logic       old_fall;
  logic       new_fall;

  assign old_clk  = pick_clk(cur_q, clk1_s, clk2_s);
  assign new_clk  = pick_clk(next_q, clk1_s, clk2_s);
  assign old_fall = old_prev_q & ~old_clk;
  assign new_fall = old_prev_q & ~new_clk;

  // Runs regardless of gate so a gated changeover still completes
  always_comb begin
    state_d    = state_q;
    cur_d      = cur_q;
    next_d     = next_q;
    cnt_d      = cnt_q;
    old_prev_d = (state_q == CKM_PARK) ? new_clk : old_clk;
    case (state_q)
      CKM_RUN: begin
        if (pick_s != cur_q) begin
          next_d  = pick_s;
          cnt_d   = `CKM_CNT_RESET;
          state_d = CKM_DRAIN;
        end
      end
      CKM_DRAIN: begin
        // Park once the old clock is low, so no high pulse is cut short; force parks at once
        if (old_fall || !old_clk || force_s) begin
          cnt_d   = `CKM_CNT_RESET;
          cur_d   = next_q;
          state_d = CKM_PARK;
        end
      end
      CKM_PARK: begin
        // A new pick restarts the park on the newest target
        if (pick_s != next_q) begin
          next_d = pick_s;
          cur_d  = pick_s;
          cnt_d  = `CKM_CNT_RESET;
        end else if (new_fall || force_s ||
                     (!new_clk && cnt_q != `CKM_CNT_RESET)) begin
          // Resume after a new low phase so the first pulse is whole
          state_d = CKM_RUN;
        end else if (!new_clk) begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      default: begin
        state_d = CKM_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      state_q    <= CKM_RUN;
      cur_q      <= 1'b0;
      next_q     <= 1'b0;
      cnt_q      <= `CKM_CNT_RESET;
      old_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      next_q     <= next_d;
      cnt_q      <= cnt_d;
      old_prev_q <= old_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  logic [NUM_OUT-1:0] out_d;
  logic [NUM_OUT-1:0] out_n_d;
  logic               act_d;

  always_comb begin
    act_d = cur_q;
    if (!pwr_n_s) begin
      out_d   = '1;
      out_n_d = '1;
    end else if (gate_n_s) begin
      // Gating is only as fast as the synchroniser allows
      out_d   = {NUM_OUT{level_s}};
      out_n_d = {NUM_OUT{~level_s}};
    end else if (state_q != CKM_PARK) begin
      // Drain keeps the old clock until it is low, so no pulse is cut
      out_d   = {NUM_OUT{old_clk}};
      out_n_d = {NUM_OUT{~old_clk}};
    end else begin
      out_d   = '0;
      out_n_d = '1;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      CLK_OUT         <= '0;
      CLK_OUT_N_OUT   <= '1;
      ACTIVE_PICK_OUT <= 1'b0;
    end else begin
      CLK_OUT         <= out_d;
      CLK_OUT_N_OUT   <= out_n_d;
      ACTIVE_PICK_OUT <= act_d;
    end
  end

endmodule : ckm_top

// ==== inc/ckm_map.svh ====
`ifndef CKM_MAP_SVH
`define CKM_MAP_SVH

// Number of differential output pairs
`define CKM_NUM_OUTPUTS 6
// Width of the control synchroniser bank
`define CKM_NUM_SYNC 7
// Bit positions inside the synchroniser bank
`define CKM_BIT_CLK1 0
`define CKM_BIT_CLK2 1
`define CKM_BIT_PICK 2
`define CKM_BIT_FORCE 3
`define CKM_BIT_GATE_N 4
`define CKM_BIT_LEVEL 5
`define CKM_BIT_PWR_N 6
// Most input-clock cycles spent draining or parking
`define CKM_PARK_MAX_CYCLES 3
// Reset value of the cycle counter
`define CKM_CNT_RESET 2'h0
// Synchroniser reset value: power-down input idle high, all else low
`define CKM_SYNC_IDLE 7'h40

`endif

// ==== inc/ckm_pkg.sv ====
package ckm_pkg;

  // Changeover sequence, Gray coded along run -> drain -> park
  typedef enum logic [1:0] {
    CKM_RUN   = 2'b00,
    CKM_DRAIN = 2'b01,
    CKM_PARK  = 2'b11
  } ckm_state_t;

endpackage : ckm_pkg

// ==== rtl/ckm_sync.sv ====
`timescale 1ns/100ps
`include "ckm_map.svh"

module ckm_sync
  import ckm_pkg::*;
#(
  parameter int WIDTH = `CKM_NUM_SYNC
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      // Idle levels, so leaving reset shows no false power down
      meta_q <= WIDTH'(`CKM_SYNC_IDLE);
      sync_q <= WIDTH'(`CKM_SYNC_IDLE);
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : ckm_sync

// ==== testbench/ckm_src_model.sv ====
`timescale 1ns/100ps
module ckm_src_model #(parameter int HALF1 = 200, parameter int HALF2 = 280) (
  input  wire logic run_in,
  output logic      clk1_out,
  output logic      clk2_out
);
  initial clk1_out = 1'b0;
  initial clk2_out = 1'b0;
  // Source one dies stuck high, the case that stalls an unforced pick
  always #(HALF1) clk1_out = run_in ? ~clk1_out : 1'b1;
  always #(HALF2) clk2_out = ~clk2_out;
endmodule : ckm_src_model

// ==== testbench/ckm_properties.sv ====
`timescale 1ns/100ps
module ckm_properties #(parameter int NUM_OUT = 6) (
  input wire logic               SYS_CLK_IN,
  input wire logic               SRST_IN,
  input wire logic               CLK1_IN,
  input wire logic               CLK2_IN,
  input wire logic               INPUT_PICK_IN,
  input wire logic               FORCE_PICK_IN,
  input wire logic               OUT_GATE_N_IN,
  input wire logic               DISABLE_LEVEL_IN,
  input wire logic               POWER_DOWN_N_IN,
  input wire logic               ACTIVE_PICK_OUT,
  input wire logic [NUM_OUT-1:0] CLK_OUT,
  input wire logic [NUM_OUT-1:0] CLK_OUT_N_OUT
);
  // Four slow-source cycles plus sync delay
  localparam int SWAP_MAX = 60;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  ////////////////////////////////////////////////////////////////
  a_reset_values: assert property (disable iff (1'b0)
    SRST_IN [*2] |-> CLK_OUT == '0 && &CLK_OUT_N_OUT && !ACTIVE_PICK_OUT) else $error("reset");
  a_powerdown_high: assert property (!POWER_DOWN_N_IN [*3] |=> &CLK_OUT && &CLK_OUT_N_OUT)
    else $error("power down");
  a_gate_level: assert property ((POWER_DOWN_N_IN && OUT_GATE_N_IN) [*3]
    |=> CLK_OUT == {NUM_OUT{$past(DISABLE_LEVEL_IN, 3)}}) else $error("gate level");
  a_pair_inverse: assert property (POWER_DOWN_N_IN [*3] |=> CLK_OUT_N_OUT == ~CLK_OUT)
    else $error("pair");
  a_fanout_same: assert property (CLK_OUT == {NUM_OUT{CLK_OUT[0]}}) else $error("fanout");
  a_pick_bound: assert property ($changed(INPUT_PICK_IN) |-> ##[1:SWAP_MAX]
    ACTIVE_PICK_OUT == INPUT_PICK_IN) else $error("pick late");
  a_park_low: assert property ($changed(ACTIVE_PICK_OUT) && $past(POWER_DOWN_N_IN, 3)
    && !$past(OUT_GATE_N_IN, 3) |-> CLK_OUT == '0) else $error("park");
  a_follow_pick: assert property ($rose(CLK_OUT[0]) && $past(POWER_DOWN_N_IN, 3)
    && !$past(OUT_GATE_N_IN, 3) |-> ACTIVE_PICK_OUT ? $past(CLK1_IN, 3) : $past(CLK2_IN, 3))
    else $error("follow");
  c_swap: cover property ($changed(ACTIVE_PICK_OUT));
  c_power: cover property (!POWER_DOWN_N_IN);
  c_gate_hi: cover property (OUT_GATE_N_IN && DISABLE_LEVEL_IN);
endmodule : ckm_properties
bind ckm_top ckm_properties #(.NUM_OUT(NUM_OUT)) i_ckm_properties (.*);

// ==== testbench/tb_ckm_top.sv ====
`timescale 1ns/100ps
module tb_ckm_top;
  logic       SYS_CLK_IN = 1'b0, SRST_IN = 1'b1, CLK1_IN, CLK2_IN, run = 1'b1;
  logic       INPUT_PICK_IN = 1'b0, FORCE_PICK_IN = 1'b0, OUT_GATE_N_IN = 1'b0;
  logic       DISABLE_LEVEL_IN = 1'b0, POWER_DOWN_N_IN = 1'b1, ACTIVE_PICK_OUT;
  logic [5:0] CLK_OUT, CLK_OUT_N_OUT;
  logic [2:0] h1 = '0, h2 = '0;
  int         mismatches = 0, checks_done = 0, seed = 32'h3654, i, k;
  always #20 SYS_CLK_IN = ~SYS_CLK_IN;
  // Model of the two-flop sampling plus the output register, so expectations track the same edges
  always @(posedge SYS_CLK_IN) begin
    h1 <= {h1[1:0], CLK1_IN};
    h2 <= {h2[1:0], CLK2_IN};
  end
  ckm_src_model i_ckm_src_model (.run_in(run), .clk1_out(CLK1_IN), .clk2_out(CLK2_IN));
  ckm_top i_ckm_top (.*);
  ////////////////////////////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(negedge SYS_CLK_IN);
  endtask : cyc
  task automatic cmp(string nm, logic [5:0] e, logic [5:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic follow(string nm);
    for (k = 0; k < 60; k++) begin
      cyc(1);
      cmp(nm, {6{INPUT_PICK_IN ? h1[2] : h2[2]}}, CLK_OUT);
      cmp({nm, "_n"}, {6{INPUT_PICK_IN ? ~h1[2] : ~h2[2]}}, CLK_OUT_N_OUT);
    end
    $display("done %s", nm);
  endtask : follow
  // Bounded wait; running out is a mismatch and ends the run
  task automatic wait_pick(logic p);
    for (i = 0; i < 80 && ACTIVE_PICK_OUT !== p; i++) cyc(1);
    cmp("pick", {5'h0_0, p}, {5'h0_0, ACTIVE_PICK_OUT});
    if (i == 80) end_sim();
  endtask : wait_pick
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(2);
    cmp("rst", 6'h00, CLK_OUT);
    cmp("rst_n", 6'h3f, CLK_OUT_N_OUT);
    SRST_IN = 1'b0;
    cyc(2);
    cmp("rst_out", 6'h00, CLK_OUT);
    cyc(8);
    follow("pick_two");
    INPUT_PICK_IN = 1'b1;
    wait_pick(1'b1);
    cyc(50);
    follow("pick_one");
    for (k = 0; k < 4; k++) begin
      DISABLE_LEVEL_IN = 1'($random(seed));
      OUT_GATE_N_IN = 1'b1;
      cyc(4);
      cmp("gate", {6{DISABLE_LEVEL_IN}}, CLK_OUT);
      cmp("gate_n", {6{~DISABLE_LEVEL_IN}}, CLK_OUT_N_OUT);
    end
    POWER_DOWN_N_IN = 1'b0;
    cyc(4);
    cmp("pwr_down", 6'h3f, CLK_OUT);
    cmp("pwr_down_n", 6'h3f, CLK_OUT_N_OUT);
    POWER_DOWN_N_IN = 1'b1;
    cyc(8);
    OUT_GATE_N_IN = 1'b0;
    $display("done gate");
    run = 1'b0;
    FORCE_PICK_IN = 1'b1;
    INPUT_PICK_IN = 1'b0;
    wait_pick(1'b0);
    FORCE_PICK_IN = 1'b0;
    run = 1'b1;
    cyc(10);
    follow("forced");
    end_sim();
  end
endmodule : tb_ckm_top
